// >>> core/mrr_core.sv
// Motion report registers: accumulators, freeze snapshot, readouts.
// Assumes motion and frame inputs come from logic on clk.
// Operation
// - Read-only revision byte, separate from firmware
// - Fixed identification byte proves link works
// - Status bit 7 flags unreported motion
// - Status bit 4 flags accumulator overflow
// - Status bit 0 shows resolution select
// - Status read freezes X and Y snapshot
// - Second status read replaces earlier snapshot
// - Wide accumulators saturate and flag overflow
// - Overflow clears after read below full scale
// - Excess motion reports saturated full scale
// - Any flush write discards all motion
// - X byte reports signed counts, clears
// - Y byte reports signed counts, clears
// - Quality byte is feature count over four
// - Quality byte never exceeds 169
// - Intensity byte is pixel sum upper byte
// - All registers reached through serial port
`timescale 1ns/10ps
module mrr_core
#(
  // Arbitrary neutral values
  parameter logic [7:0] ID_CODE = 8'h5a,
  parameter logic [7:0] REV_CODE = 8'h01
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial port pins
  input wire logic ncs_pin,
  input wire logic sclk_pin,
  input wire logic mosi_pin,
  output logic miso,
  output logic miso_oe,
  // Motion from the navigation engine
  input wire logic motion_valid,
  input wire logic [7:0] motion_dx,
  input wire logic [7:0] motion_dy,
  input wire logic cpi_select_flag,
  // Frame statistics
  input wire logic frame_valid,
  input wire logic [9:0] feature_count,
  input wire logic [15:0] pixel_total
);
  localparam int AW = mrr_pkg::ACC_W;
  localparam int SW = mrr_pkg::SUM_W;

  logic rd_req;
  logic wr_req;
  logic [6:0] addr;
  logic [7:0] wr_data;
  logic [7:0] rdata_r;
  logic signed [AW-1:0] accx_r;
  logic signed [AW-1:0] accy_r;
  logic signed [AW-1:0] accx_nxt;
  logic signed [AW-1:0] accy_nxt;
  logic signed [SW-1:0] sumx;
  logic signed [SW-1:0] sumy;
  logic [7:0] snapx_r;
  logic [7:0] snapy_r;
  logic movement_pending;
  logic accum_overflow;
  logic rd_stat;
  logic rd_x;
  logic rd_y;
  logic flush;
  logic ovf_evt;
  logic [7:0] status_byte;
  logic [7:0] quality_r;
  logic [7:0] intensity_r;
  logic [7:0] addx;
  logic [7:0] addy;

  function automatic logic signed [SW-1:0] acc_sum(
    input logic signed [AW-1:0] a,
    input logic signed [7:0] d,
    input logic signed [7:0] s);
    acc_sum = SW'(a) + SW'(d) - SW'(s);
  endfunction

  function automatic logic over(input logic signed [SW-1:0] v);
    over = (v > mrr_pkg::SUM_MAX) || (v < mrr_pkg::SUM_MIN);
  endfunction

  function automatic logic signed [AW-1:0] sat_acc(
    input logic signed [SW-1:0] v);
    if (v > mrr_pkg::SUM_MAX)
      sat_acc = mrr_pkg::ACC_MAX;
    else if (v < mrr_pkg::SUM_MIN)
      sat_acc = mrr_pkg::ACC_MIN;
    else
      sat_acc = v[AW-1:0];
  endfunction

  function automatic logic [7:0] sat8(input logic signed [AW-1:0] a);
    if (a > mrr_pkg::REP_MAX)
      sat8 = 8'h7f;
    else if (a < mrr_pkg::REP_MIN)
      sat8 = 8'h80;
    else
      sat8 = a[7:0];
  endfunction

  function automatic logic full(input logic signed [AW-1:0] a);
    full = (a == mrr_pkg::ACC_MAX) || (a == mrr_pkg::ACC_MIN);
  endfunction

  mrr_serial u_serial
  (
    .clk(clk),
    .rst(rst),
    .ncs_pin(ncs_pin),
    .sclk_pin(sclk_pin),
    .mosi_pin(mosi_pin),
    .miso(miso),
    .miso_oe(miso_oe),
    .rd_data(rdata_r),
    .rd_req(rd_req),
    .wr_req(wr_req),
    .addr(addr),
    .wr_data(wr_data)
  );

  // Flush data byte is ignored; any write counts
  assign flush = wr_req && addr == mrr_pkg::ADDR_FLUSH;
  assign rd_stat = rd_req && addr == mrr_pkg::ADDR_STAT;
  assign rd_x = rd_req && addr == mrr_pkg::ADDR_DX;
  assign rd_y = rd_req && addr == mrr_pkg::ADDR_DY;
  assign addx = motion_valid ? motion_dx : 8'h00;
  assign addy = motion_valid ? motion_dy : 8'h00;

  // Reported amount leaves the accumulator, rest stays
  assign sumx = acc_sum(accx_r, addx, rd_x ? snapx_r : 8'h00);
  assign sumy = acc_sum(accy_r, addy, rd_y ? snapy_r : 8'h00);
  assign ovf_evt = over(sumx) | over(sumy);

  always_comb
  begin
    accx_nxt = sat_acc(sumx);
    accy_nxt = sat_acc(sumy);
    if (flush)
    begin
      // Motion arriving with the flush is dropped too
      accx_nxt = mrr_pkg::RST_ACC;
      accy_nxt = mrr_pkg::RST_ACC;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      accx_r <= mrr_pkg::RST_ACC;
      accy_r <= mrr_pkg::RST_ACC;
    end
    else
    begin
      accx_r <= accx_nxt;
      accy_r <= accy_nxt;
    end
  end

  // Pending tracks anything left to report
  always_ff @(posedge clk)
  begin
    if (rst)
      movement_pending <= 1'b0;
    else
      movement_pending <= (accx_nxt != 0) || (accy_nxt != 0);
  end

  // Overflow event wins over a read clear in the same cycle; a flush clears it regardless
  always_ff @(posedge clk)
  begin
    if (rst || flush)
      accum_overflow <= 1'b0;
    else if (ovf_evt)
      accum_overflow <= 1'b1;
    else if ((rd_x || rd_y) && !full(accx_nxt) && !full(accy_nxt))
      accum_overflow <= 1'b0;
  end

  // Snapshot is saturated so large motion reads as full scale
  always_ff @(posedge clk)
  begin
    if (rst || flush)
    begin
      snapx_r <= mrr_pkg::RST_BYTE;
      snapy_r <= mrr_pkg::RST_BYTE;
    end
    else if (rd_stat)
    begin
      snapx_r <= sat8(accx_r);
      snapy_r <= sat8(accy_r);
    end
    else
    begin
      if (rd_x)
        snapx_r <= mrr_pkg::RST_BYTE;
      if (rd_y)
        snapy_r <= mrr_pkg::RST_BYTE;
    end
  end

  // Frame statistics, refreshed every frame
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      quality_r <= mrr_pkg::RST_BYTE;
      intensity_r <= mrr_pkg::RST_BYTE;
    end
    else if (frame_valid)
    begin
      // Clamp guards against an out-of-range count
      quality_r <= (feature_count[9:2] > mrr_pkg::SQ_MAX)
                   ? mrr_pkg::SQ_MAX : feature_count[9:2];
      intensity_r <= pixel_total[15:8];
    end
  end

  always_comb
  begin
    status_byte = 8'h00;
    status_byte[mrr_pkg::STAT_MOT_BIT] = movement_pending;
    status_byte[mrr_pkg::STAT_OVF_BIT] = accum_overflow;
    status_byte[mrr_pkg::STAT_CPI_BIT] = cpi_select_flag;
  end

  // Read data is registered one cycle after the address byte
  always_ff @(posedge clk)
  begin
    if (rst)
      rdata_r <= mrr_pkg::RST_BYTE;
    else if (rd_req)
    begin
      case (addr)
        mrr_pkg::ADDR_ID:
          rdata_r <= ID_CODE;
        mrr_pkg::ADDR_REV:
          rdata_r <= REV_CODE;
        mrr_pkg::ADDR_STAT:
          rdata_r <= status_byte;
        mrr_pkg::ADDR_DX:
          rdata_r <= snapx_r;
        mrr_pkg::ADDR_DY:
          rdata_r <= snapy_r;
        mrr_pkg::ADDR_SQ:
          rdata_r <= quality_r;
        mrr_pkg::ADDR_SUM:
          rdata_r <= intensity_r;
        default:
          rdata_r <= mrr_pkg::RST_BYTE;
      endcase
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  chk_rev_value: assert property (
    rd_req && addr == mrr_pkg::ADDR_REV |=> rdata_r == REV_CODE)
    else $error("revision read wrong");

  chk_id_fixed: assert property (
    rd_req && addr == mrr_pkg::ADDR_ID |=> rdata_r == ID_CODE)
    else $error("identification read wrong");

  chk_mot_tracks: assert property (
    movement_pending == ((accx_r != 0) || (accy_r != 0)))
    else $error("motion flag out of step");

  chk_status_bits: assert property (
    rd_stat |=> rdata_r[4] == $past(accum_overflow)
      && rdata_r[7] == $past(movement_pending))
    else $error("status bits misplaced");

  chk_cpi_bit: assert property (
    rd_stat |=> rdata_r[0] == $past(cpi_select_flag))
    else $error("resolution bit wrong");

  chk_freeze_snap: assert property (
    rd_stat |=> snapx_r == sat8($past(accx_r))
      && snapy_r == sat8($past(accy_r)))
    else $error("snapshot not frozen");

  chk_relatch_snap: assert property (
    rd_stat && snapy_r != 8'h00
      |=> snapy_r == sat8($past(accy_r)))
    else $error("second status read kept old snapshot");

  chk_ovf_set: assert property (
    ovf_evt && !flush |=> accum_overflow ##1 (accum_overflow || rd_x
      || rd_y || $past(flush) || $past(rd_x || rd_y)))
    else $error("overflow not flagged");

  chk_ovf_clear: assert property (
    rd_x && !ovf_evt && !flush && !full(accx_nxt) && !full(accy_nxt)
      |=> !accum_overflow)
    else $error("overflow not cleared");

  chk_sat_report: assert property (
    rd_stat && accx_r > mrr_pkg::REP_MAX |=> snapx_r == 8'h7f)
    else $error("saturated report missing");

  chk_flush_all: assert property (
    flush |=> accx_r == 0 && accy_r == 0 && !movement_pending
      && snapx_r == 8'h00 && snapy_r == 8'h00)
    else $error("flush left motion");

  chk_dx_clear: assert property (
    rd_x && !flush |=> rdata_r == $past(snapx_r) && snapx_r == 8'h00)
    else $error("X read did not clear");

  chk_dy_clear: assert property (
    rd_y && !flush |=> rdata_r == $past(snapy_r) && snapy_r == 8'h00)
    else $error("Y read did not clear");

  chk_quality_map: assert property (
    frame_valid && feature_count[9:2] <= mrr_pkg::SQ_MAX
      |=> quality_r == $past(feature_count[9:2]))
    else $error("quality not count over four");

  chk_quality_max: assert property (
    quality_r <= mrr_pkg::SQ_MAX)
    else $error("quality above limit");

  chk_sum_byte: assert property (
    frame_valid |=> intensity_r == $past(pixel_total[15:8]))
    else $error("intensity byte wrong");

  chk_drain_sub: assert property (
    rd_x && !motion_valid && !flush
      |=> accx_r == $past(accx_r) - AW'($signed($past(snapx_r))))
    else $error("read did not subtract");
endmodule // mrr_core

// >>> common/mrr_pkg.sv
// Shared constants for the motion report register block.
// Assumes a single 100 MHz core clock and a byte-wide serial port.
package mrr_pkg;
  localparam int ACC_W = 12;
  localparam int SUM_W = 14;
  // Register offsets on the serial port
  localparam logic [6:0] ADDR_ID = 7'h00;
  localparam logic [6:0] ADDR_REV = 7'h01;
  localparam logic [6:0] ADDR_STAT = 7'h02;
  localparam logic [6:0] ADDR_DX = 7'h03;
  localparam logic [6:0] ADDR_DY = 7'h04;
  localparam logic [6:0] ADDR_SQ = 7'h05;
  localparam logic [6:0] ADDR_SUM = 7'h06;
  localparam logic [6:0] ADDR_FLUSH = 7'h12;
  // Status field positions
  localparam int STAT_MOT_BIT = 7;
  localparam int STAT_OVF_BIT = 4;
  localparam int STAT_CPI_BIT = 0;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [ACC_W-1:0] RST_ACC = 12'h000;
  // Limits
  localparam logic signed [ACC_W-1:0] ACC_MAX = 12'sh7ff;
  localparam logic signed [ACC_W-1:0] ACC_MIN = 12'sh800;
  localparam logic signed [SUM_W-1:0] SUM_MAX = 14'sh07ff;
  localparam logic signed [SUM_W-1:0] SUM_MIN = 14'sh3800;
  localparam logic signed [ACC_W-1:0] REP_MAX = 12'sh07f;
  localparam logic signed [ACC_W-1:0] REP_MIN = 12'shf80;
  localparam logic [7:0] SQ_MAX = 8'ha9;
  // Serial framing
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int WR_BIT = 7;
  typedef enum logic [1:0] {
    PH_ADDR = 2'b00,
    PH_READ = 2'b01,
    PH_WRITE = 2'b10,
    PH_DONE = 2'b11
  } mrr_phase_e;
endpackage

// >>> core/mrr_serial.sv
// Four-wire serial slave: address byte (bit 7 set = write) then data.
// Assumes pins are asynchronous; idle-high clock, sample on rise.
`timescale 1ns/10ps
module mrr_serial
(
  // Core clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial pins
  input wire logic ncs_pin,
  input wire logic sclk_pin,
  input wire logic mosi_pin,
  output logic miso,
  output logic miso_oe,
  // Register side
  input wire logic [7:0] rd_data,
  output logic rd_req,
  output logic wr_req,
  output logic [6:0] addr,
  output logic [7:0] wr_data
);
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic sclk_d_r;
  logic [3:0] cnt_r;
  logic [7:0] rx_r;
  logic [7:0] tx_r;
  mrr_pkg::mrr_phase_e phase_r;
  logic sel;
  logic rise;
  logic fall;
  logic [7:0] rx_nxt;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync1_r <= 3'h7;
      sync2_r <= 3'h7;
      sclk_d_r <= 1'b1;
    end
    else
    begin
      sync1_r <= {ncs_pin, sclk_pin, mosi_pin};
      sync2_r <= sync1_r;
      sclk_d_r <= sync2_r[1];
    end
  end

  assign sel = ~sync2_r[2];
  assign rise = sel & sync2_r[1] & ~sclk_d_r;
  assign fall = sel & ~sync2_r[1] & sclk_d_r;
  assign rx_nxt = {rx_r[6:0], sync2_r[0]};

  // Register access only through this port
  always_ff @(posedge clk)
  begin
    rd_req <= 1'b0;
    wr_req <= 1'b0;
    if (rst | ~sel)
    begin
      cnt_r <= 4'h0;
      rx_r <= 8'h00;
      phase_r <= mrr_pkg::PH_ADDR;
      addr <= 7'h00;
      wr_data <= 8'h00;
    end
    else if (rise)
    begin
      rx_r <= rx_nxt;
      cnt_r <= cnt_r + 4'h1;
      if (cnt_r + 4'h1 == mrr_pkg::BYTE_BITS)
      begin
        cnt_r <= 4'h0;
        case (phase_r)
          mrr_pkg::PH_ADDR:
          begin
            addr <= rx_nxt[6:0];
            rd_req <= ~rx_nxt[mrr_pkg::WR_BIT];
            phase_r <= rx_nxt[mrr_pkg::WR_BIT] ? mrr_pkg::PH_WRITE
                                               : mrr_pkg::PH_READ;
          end
          mrr_pkg::PH_WRITE:
          begin
            wr_data <= rx_nxt;
            wr_req <= 1'b1;
            phase_r <= mrr_pkg::PH_DONE;
          end
          mrr_pkg::PH_READ:
            phase_r <= mrr_pkg::PH_DONE;
          default:
            phase_r <= mrr_pkg::PH_DONE;
        endcase
      end
    end
  end

  // Data loads at the first falling edge of the read byte
  always_ff @(posedge clk)
  begin
    if (rst | ~sel)
      tx_r <= 8'h00;
    else if (fall && phase_r == mrr_pkg::PH_READ)
      tx_r <= (cnt_r == 4'h0) ? rd_data : {tx_r[6:0], 1'b0};
  end

  assign miso = tx_r[7];
  assign miso_oe = sel;
endmodule // mrr_serial

// >>> dv/mrr_master_model.sv
// Serial port master standing in for the external controller.
// Assumes the core clock paces it; sclk idles high, half period 4 clk.
`timescale 1ns/10ps
module mrr_master_model
(
  // Clock
  input wire logic clk,
  // Serial pins
  output logic ncs_pin,
  output logic sclk_pin,
  output logic mosi_pin,
  input wire logic miso
);
  initial
  begin
    ncs_pin = 1'b1;
    sclk_pin = 1'b1;
    mosi_pin = 1'b0;
  end
  // One address byte then one data byte per select frame
  task automatic xfer(input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q);
    logic [15:0] sh;
    sh = {a, d};
    q = 8'h00;
    @(posedge clk) ncs_pin <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 16; i++)
    begin
      sclk_pin <= 1'b0;
      mosi_pin <= sh[15-i];
      repeat (4) @(posedge clk);
      sclk_pin <= 1'b1;
      repeat (4) @(posedge clk);
      // Late in the high half: bit is settled past the sync lag
      if (i > 7)
        q = {q[6:0], miso};
    end
    ncs_pin <= 1'b1;
    // Released line must not keep its last value
    mosi_pin <= ~mosi_pin;
    repeat (6) @(posedge clk);
  endtask
endmodule // mrr_master_model

// >>> dv/test_motion_report_registers.sv
// Self-checking bench for the motion report register core.
// Assumes the master model in dv/ and the core's default timing.
`timescale 1ns/10ps
module test_motion_report_registers;
  localparam logic [7:0] ID_V = 8'h3c; // Arbitrary
  localparam logic [7:0] REV_V = 8'h01;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ncs_pin, sclk_pin, mosi_pin, miso, miso_oe;
  logic motion_valid = 1'b0;
  logic [7:0] motion_dx = 8'h00;
  logic [7:0] motion_dy = 8'h00;
  logic cpi_select_flag = 1'b0;
  logic frame_valid = 1'b0;
  logic [9:0] feature_count = 10'h000;
  logic [15:0] pixel_total = 16'h0000;
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;
  int ax = 0;
  int ay = 0;
  logic [7:0] sx = 8'h00;
  logic [7:0] sy = 8'h00;
  logic ovf = 1'b0;
  logic cpi = 1'b0;
  logic [15:0] rnd = 16'hdbec;
  logic [7:0] q;
  logic [7:0] rv [8];

  always #5 clk = ~clk;

  mrr_core #(.ID_CODE(ID_V), .REV_CODE(REV_V)) mrr_core_inst
  (
    .clk(clk), .rst(rst), .ncs_pin(ncs_pin), .sclk_pin(sclk_pin),
    .mosi_pin(mosi_pin), .miso(miso), .miso_oe(miso_oe),
    .motion_valid(motion_valid), .motion_dx(motion_dx),
    .motion_dy(motion_dy), .cpi_select_flag(cpi_select_flag),
    .frame_valid(frame_valid), .feature_count(feature_count),
    .pixel_total(pixel_total)
  );
  mrr_master_model mrr_master_model_inst
  (
    .clk(clk), .ncs_pin(ncs_pin), .sclk_pin(sclk_pin),
    .mosi_pin(mosi_pin), .miso(miso)
  );

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic [7:0] sat8(input int v);
    return v > 127 ? 8'h7f : (v < -128 ? 8'h80 : 8'(v));
  endfunction
  function automatic logic [7:0] sq_exp(input logic [9:0] f);
    return f[9:2] > 8'ha9 ? 8'ha9 : f[9:2];
  endfunction

  task automatic check(input string nm, input logic [7:0] seen,
    input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic bus(input logic [7:0] a, input logic [7:0] d);
    mrr_master_model_inst.xfer(a, d, q);
  endtask
  task automatic acc(inout int a, input logic [7:0] d);
    a += int'($signed(d));
    if (a > 2047 || a < -2048)
      ovf = 1'b1;
    a = a > 2047 ? 2047 : (a < -2048 ? -2048 : a);
  endtask
  task automatic mv(input logic [7:0] dx, input logic [7:0] dy);
    @(posedge clk);
    motion_valid <= 1'b1;
    motion_dx <= dx;
    motion_dy <= dy;
    @(posedge clk);
    motion_valid <= 1'b0;
    acc(ax, dx);
    acc(ay, dy);
  endtask
  task automatic rd_stat();
    bus(8'h02, 8'h00);
    check("status", q, {ax != 0 || ay != 0, 2'b00, ovf, 3'b000, cpi});
    sx = sat8(ax);
    sy = sat8(ay);
  endtask
  task automatic rd_xy(input bit is_y);
    bus(is_y ? 8'h04 : 8'h03, 8'h00);
    check(is_y ? "y_disp" : "x_disp", q, is_y ? sy : sx);
    if (is_y)
      ay -= int'($signed(sy));
    else
      ax -= int'($signed(sx));
    if (is_y)
      sy = 8'h00;
    else
      sx = 8'h00;
    if (ax != 2047 && ax != -2048 && ay != 2047 && ay != -2048)
      ovf = 1'b0;
  endtask
  task automatic frame(input logic [9:0] f, input logic [15:0] p);
    @(posedge clk);
    frame_valid <= 1'b1;
    feature_count <= f;
    pixel_total <= p;
    @(posedge clk);
    frame_valid <= 1'b0;
    bus(8'h05, 8'h00);
    check("quality", q, sq_exp(f));
    bus(8'h06, 8'h00);
    check("intensity", q, p[15:8]);
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      err_count++;
      wrap_up();
    end
  end

  initial
  begin
    rv = '{ID_V, REV_V, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // 0x07 is unmapped and must read zero
    for (int i = 0; i < 8; i++)
    begin
      bus({1'b0, 7'(i)}, 8'h00);
      check("reset_reg", q, rv[i]);
    end
    // Enable must rise while the frame is still open
    fork
      bus(8'h01, 8'h00);
      begin
        repeat (8) @(posedge clk);
        check("miso_oe_on", {7'h00, miso_oe}, 8'h01);
      end
    join
    check("rev_again", q, REV_V);
    check("miso_oe", {7'h00, miso_oe}, 8'h00);
    $display("reset values done");
    for (int c = 0; c < 2; c++)
    begin
      cpi_select_flag <= c[0];
      cpi = c[0];
      @(posedge clk);
      rd_stat();
    end
    $display("resolution flag done");
    repeat (6)
    begin
      rnd = lfsr(rnd);
      mv({{2{rnd[5]}}, rnd[5:0]}, {{2{rnd[11]}}, rnd[11:6]});
      rd_stat();
      // Motion after the status read stays out of the snapshot
      mv(8'h05, 8'hfb);
      rd_xy(0);
      if (rnd[12])
        rd_stat();
      rd_xy(1);
    end
    $display("snapshot order done");
    repeat (20)
      mv(8'h7f, 8'h80);
    rd_stat();
    rd_xy(0);
    rd_xy(1);
    for (int n = 0; n < 40; n++)
    begin
      rd_stat();
      if (ax == 0 && ay == 0)
        break;
      rd_xy(0);
      rd_xy(1);
    end
    $display("overflow drain done");
    mv(8'h33, 8'hc0);
    rd_stat();
    rnd = lfsr(rnd);
    bus(8'h92, rnd[7:0]);
    ax = 0;
    ay = 0;
    sx = 8'h00;
    sy = 8'h00;
    ovf = 1'b0;
    rd_xy(0);
    rd_stat();
    $display("flush done");
    frame(10'h3ff, 16'hffff);
    frame(10'h2a4, 16'h0100);
    frame(10'h2a8, 16'h00ff);
    repeat (4)
    begin
      rnd = lfsr(rnd);
      frame(rnd[9:0], {rnd[3:0], rnd[15:4]});
    end
    $display("frame stats done");
    wrap_up();
  end
endmodule // test_motion_report_registers
